/* test/rkd_adc_model.sv */
// partner: converter sampling the button ladder every other clock
module rkd_adc_model (
  input wire logic mclk,
  input wire logic [7:0] level,
  output rkd_pkg::rkd_sample_s sample
);
  timeunit 1ns;
  timeprecision 1ns;
  initial sample = '0;
  // code is scrambled between conversions so a stale read is not a match
  always @(posedge mclk) begin
    sample.valid <= !sample.valid;
    sample.code <= !sample.valid ? level : ~sample.code;
  end
endmodule // rkd_adc_model

/* test/rkd_keypad_blinker_tb.sv */
// testbench: decode table, start-up blinks and test mode bursts
module rkd_keypad_blinker_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst_n = 0, strap_n = 1, led_drive, lp = 0;
  logic [7:0] level = 8'hf0;
  rkd_pkg::rkd_sample_s sample;
  rkd_pkg::rkd_button_s button;
  int fails = 0, tests_run = 0, rises = 0, cyc = 0, valids = 0, v0 = 0;
  logic [10:0] rows [13] = '{11'h780, 11'h779, 11'h509, 11'h503, 11'h3c3, 11'h3be, 11'h266, 11'h25c,
    11'h13c, 11'h132, 11'h072, 11'h06d, 11'h005};
  logic [7:0] codes [6] = '{8'ha1, 8'h0e, 8'h78, 8'h27, 8'h00, 8'h4c};
  rkd_adc_model rkd_adc_model_i (.mclk(mclk), .level(level), .sample(sample));
  rkd_keypad_blinker #(.BLINK_ON_CYCLES(4), .BLINK_OFF_CYCLES(4), .GAP_CYCLES(20)) rkd_keypad_blinker_i (
    .mclk(mclk), .rst_n(rst_n), .sample(sample), .test_mode_select_pin_n(strap_n), .led_drive(led_drive),
    .button(button));
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) begin
    lp <= led_drive;
    rises <= rises + int'(led_drive && !lp);
    valids <= valids + int'(button.valid);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      stop_test();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic count(input int k, input int exp);
    int r0;
    r0 = rises;
    wait_cyc(k);
    check(8'(rises - r0), 8'(exp));
  endtask
  task automatic power_up(input logic s);
    rst_n = 0;
    strap_n = s;
    wait_cyc(6);
    rst_n = 1;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    power_up(1'b1);
    check(8'(led_drive), 8'h00);
    check(8'(button), 8'h00);
    foreach (rows[i]) begin
      level = rows[i][10:3];
      wait_cyc(4);
      check(8'(button.id), 8'(rows[i][2:0]));
    end
    check(8'(rises), 8'h00);
    check(8'(valids != 0), 8'h01);
    // strap moved without a power cycle must not enter test mode
    strap_n = 0;
    level = 8'ha1;
    count(60, 0);
    level = 8'hf0;
    power_up(1'b0);
    v0 = valids;
    count(60, 5);
    for (int k = 0; k < 6; k++) begin
      level = codes[k];
      count(8 * k + 14, k + 1);
      count(8 * k + 24, k + 1);
      level = 8'hf0;
      wait_cyc(30);
      count(40, 0);
    end
    check(8'(valids - v0), 8'h00);
    stop_test();
  end
endmodule // rkd_keypad_blinker_tb

/* test/rkd_props.sv */
// checker: port-level properties of the keypad decoder and led blinker
module rkd_props #(
  parameter int BLINK_ON_CYCLES = 4,
  parameter int BLINK_OFF_CYCLES = 4,
  parameter int GAP_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire rkd_pkg::rkd_sample_s sample,
  input wire logic test_mode_select_pin_n,
  input wire logic led_drive,
  input wire rkd_pkg::rkd_button_s button
);
  logic l = 1'b0;
  int n = 0;
  function automatic logic [2:0] dec(input logic [7:0] c);
    return c >= 8'hf0 ? 3'h0 : c >= 8'ha1 ? 3'h1 : c >= 8'h78 ? 3'h3 : c >= 8'h4c ? 3'h6 :
      c >= 8'h27 ? 3'h4 : c >= 8'h0e ? 3'h2 : 3'h5;
  endfunction
  // n is the length of the led's previous level run at each change
  always_ff @(posedge mclk) begin
    l <= led_drive;
    n <= (led_drive == l) ? n + 1 : 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_reset_dark: assert property (disable iff (1'b0) !rst_n |=> !led_drive && button == '0)
    else $error("outputs not cleared in reset");
  chk_decode_map: assert property (sample.valid |=> button.id == dec($past(sample.code)))
    else $error("wrong button decode");
  chk_id_hold: assert property (!$past(sample.valid) |-> $stable(button.id))
    else $error("button id moved without sample");
  chk_valid_pulse: assert property (button.valid |=> !button.valid)
    else $error("button valid longer than one cycle");
  chk_valid_cause: assert property (button.valid |-> $past(sample.valid))
    else $error("button valid without sample");
  chk_user_dark: assert property (test_mode_select_pin_n |-> !led_drive)
    else $error("led lit in user mode");
  chk_on_len: assert property ($fell(led_drive) |-> n == BLINK_ON_CYCLES)
    else $error("blink on time wrong");
  chk_off_len: assert property ($rose(led_drive) |-> n == BLINK_OFF_CYCLES || n >= GAP_CYCLES)
    else $error("blink off time wrong");
endmodule // rkd_props

bind rkd_keypad_blinker rkd_props #(.BLINK_ON_CYCLES(BLINK_ON_CYCLES), .BLINK_OFF_CYCLES(BLINK_OFF_CYCLES),
  .GAP_CYCLES(GAP_CYCLES)) rkd_props_i (.mclk(mclk), .rst_n(rst_n), .sample(sample),
  .test_mode_select_pin_n(test_mode_select_pin_n), .led_drive(led_drive), .button(button));

/* verilog/rkd_keypad_blinker.sv */
// module: resistor ladder keypad decode and indicator led blinker
// Functional notes
// RQ1 - led output high lights both leds
// RQ2 - led output off from power-on
// RQ3 - six buttons read from one converter code
// RQ4 - idle, power, play lower bounds decode
// RQ5 - forward, reverse, pause, stop lower bounds
// RQ6 - test mode blinks five times at start
// RQ7 - held button blinks its index count
// RQ8 - two second gap, repeat until release
// RQ9 - test strap sampled once at power-up
// RQ10 - highest bound not above code wins
// RQ11 - user mode forwards button, no blinking
module rkd_keypad_blinker #(
  parameter int BLINK_ON_CYCLES = rkd_pkg::BLINK_ON_CYC,
  parameter int BLINK_OFF_CYCLES = rkd_pkg::BLINK_OFF_CYC,
  parameter int GAP_CYCLES = rkd_pkg::GAP_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire rkd_pkg::rkd_sample_s sample,
  input wire logic test_mode_select_pin_n,
  output logic led_drive,
  output rkd_pkg::rkd_button_s button
);
  // ******************************************************************
  // ladder decode
  // ******************************************************************
  // bounds in falling order; the idle bound heads the table
  localparam int NUM_BOUNDS = 7;
  localparam logic [7:0] BOUND [NUM_BOUNDS] = '{
    rkd_pkg::IDLE_MIN,
    rkd_pkg::POWER_MIN,
    rkd_pkg::PLAY_MIN,
    rkd_pkg::FORWARD_MIN,
    rkd_pkg::REVERSE_MIN,
    rkd_pkg::PAUSE_MIN,
    rkd_pkg::STOP_MIN
  };
  localparam logic [2:0] BOUND_ID [NUM_BOUNDS] = '{
    rkd_pkg::BTN_NONE,
    rkd_pkg::BTN_POWER,
    rkd_pkg::BTN_PLAY,
    rkd_pkg::BTN_FORWARD,
    rkd_pkg::BTN_REVERSE,
    rkd_pkg::BTN_PAUSE,
    rkd_pkg::BTN_STOP
  };

  logic [NUM_BOUNDS-1:0] at_or_above;
  logic [NUM_BOUNDS-1:0] first_hit;
  logic [2:0] pick_id [NUM_BOUNDS];
  logic [2:0] merged_id [NUM_BOUNDS+1];
  logic [2:0] decoded;

  // one shared converter input carries all six buttons
  assign merged_id[0] = rkd_pkg::BTN_NONE; // [RQ3]

  generate
    for (genvar i = 0; i < NUM_BOUNDS; i++) begin : g_bound
      assign at_or_above[i] = sample.code >= BOUND[i]; // [RQ4] [RQ5]
      if (i == 0) begin : g_top
        assign first_hit[i] = at_or_above[i]; // [RQ10]
      end else begin : g_lower
        // the highest bound not above the code wins, lower ones are masked
        assign first_hit[i] = at_or_above[i] & ~at_or_above[i - 1]; // [RQ10]
      end
      // exactly one entry hits, so an or-merge of the picks is enough
      assign pick_id[i] = first_hit[i] ? BOUND_ID[i] : rkd_pkg::BTN_NONE;
      assign merged_id[i + 1] = merged_id[i] | pick_id[i];
    end
  endgenerate

  assign decoded = merged_id[NUM_BOUNDS];

  // ******************************************************************
  // state
  // ******************************************************************
  rkd_pkg::rkd_state_s r;
  rkd_pkg::rkd_state_s next_r;
  logic [2:0] held;

  always_comb begin
    next_r = r;
    next_r.sel_s1 = test_mode_select_pin_n;
    next_r.sel_s2 = r.sel_s1;
    next_r.button.valid = 1'b0;
    if (sample.valid) begin
      next_r.button.id = decoded;
      // user mode passes each decoded reading taken in ST_IDLE on
      next_r.button.valid = ~r.test_mode && r.state == rkd_pkg::ST_IDLE; // [RQ11]
    end
    held = next_r.button.id;
    if (r.timer != 28'h0000000) begin
      next_r.timer = r.timer - 28'h0000001;
    end
    case (r.state)
      rkd_pkg::ST_STRAP: begin
        // strap settled through synchroniser; caught once, never again
        if (r.timer == 28'h0000000) begin
          next_r.test_mode = ~r.sel_s2; // [RQ9]
          if (~r.sel_s2) begin
            next_r.state = rkd_pkg::ST_ON; // [RQ6]
            next_r.left = rkd_pkg::STARTUP_BLINKS;
            next_r.burst = rkd_pkg::BTN_NONE;
            next_r.led = 1'b1; // [RQ1]
            next_r.timer = 28'(BLINK_ON_CYCLES - 1);
          end else begin
            next_r.state = rkd_pkg::ST_IDLE; // [RQ11]
          end
        end
      end
      rkd_pkg::ST_ON: begin
        if (r.timer == 28'h0000000) begin
          next_r.led = 1'b0;
          next_r.left = r.left - 3'h1;
          next_r.state = rkd_pkg::ST_OFF;
          next_r.timer = 28'(BLINK_OFF_CYCLES - 1);
        end
      end
      rkd_pkg::ST_OFF: begin
        if (r.timer == 28'h0000000) begin
          if (r.left != 3'h0) begin
            next_r.led = 1'b1; // [RQ7]
            next_r.state = rkd_pkg::ST_ON;
            next_r.timer = 28'(BLINK_ON_CYCLES - 1);
          end else if (r.burst == rkd_pkg::BTN_NONE) begin
            next_r.state = rkd_pkg::ST_IDLE;
          end else begin
            next_r.state = rkd_pkg::ST_GAP; // [RQ8]
            next_r.timer = 28'(GAP_CYCLES - 1);
          end
        end
      end
      rkd_pkg::ST_GAP: begin
        // release ends the repetition at once
        if (held != r.burst) begin // [RQ8]
          next_r.state = rkd_pkg::ST_IDLE;
          next_r.timer = 28'h0000000;
        end else if (r.timer == 28'h0000000) begin
          next_r.led = 1'b1; // [RQ8]
          next_r.left = r.burst;
          next_r.state = rkd_pkg::ST_ON;
          next_r.timer = 28'(BLINK_ON_CYCLES - 1);
        end
      end
      rkd_pkg::ST_IDLE: begin
        // a press seen mid-burst is not queued; it is picked up once back here
        if (r.test_mode && sample.valid && decoded != rkd_pkg::BTN_NONE) begin
          next_r.burst = decoded; // [RQ7]
          next_r.left = decoded;
          next_r.led = 1'b1; // [RQ1]
          next_r.state = rkd_pkg::ST_ON;
          next_r.timer = 28'(BLINK_ON_CYCLES - 1);
        end
      end
      default: begin
        next_r.state = rkd_pkg::ST_IDLE;
        next_r.led = 1'b0;
      end
    endcase
  end

  // ******************************************************************
  // registers
  // ******************************************************************
  // reset holds the led dark; sync flops preset to the user-mode level
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      r <= '0; // [RQ2]
      r.state <= rkd_pkg::ST_STRAP;
      r.timer <= rkd_pkg::STRAP_WAIT_CYC; // [RQ9]
      r.sel_s1 <= 1'b1;
      r.sel_s2 <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ******************************************************************
  // outputs
  // ******************************************************************
  // both come straight from flops so the driver stage sees no glitches
  assign led_drive = r.led; // [RQ1]
  assign button = r.button; // [RQ11]
endmodule // rkd_keypad_blinker

/* verilog/rkd_pkg.sv */
// package: constants and carrier types for the resistor keypad decoder and led blinker
package rkd_pkg;
  // ******************************************************************
  // converter lower bounds (integer codes, fractions rounded up)
  // ******************************************************************
  localparam logic [7:0] IDLE_MIN = 8'hf0;    // 239.7
  localparam logic [7:0] POWER_MIN = 8'ha1;   // 160.3
  localparam logic [7:0] PLAY_MIN = 8'h78;    // 120
  localparam logic [7:0] FORWARD_MIN = 8'h4c; // 75.1
  localparam logic [7:0] REVERSE_MIN = 8'h27; // 38.4
  localparam logic [7:0] PAUSE_MIN = 8'h0e;   // 13.9
  localparam logic [7:0] STOP_MIN = 8'h00;

  // ******************************************************************
  // button indices (also blink counts in test mode) and the start-up blink count
  // ******************************************************************
  localparam logic [2:0] BTN_NONE = 3'h0;
  localparam logic [2:0] BTN_POWER = 3'h1;
  localparam logic [2:0] BTN_PAUSE = 3'h2;
  localparam logic [2:0] BTN_PLAY = 3'h3;
  localparam logic [2:0] BTN_REVERSE = 3'h4;
  localparam logic [2:0] BTN_STOP = 3'h5;
  localparam logic [2:0] BTN_FORWARD = 3'h6;
  localparam logic [2:0] STARTUP_BLINKS = 3'h5;

  // ******************************************************************
  // timing
  // ******************************************************************
  localparam int CLK_HZ = 25000000;
  localparam int BLINK_ON_MS = 200;
  localparam int BLINK_OFF_MS = 200;
  localparam int GAP_MS = 2000;
  localparam int BLINK_ON_CYC = CLK_HZ / 1000 * BLINK_ON_MS;
  localparam int BLINK_OFF_CYC = CLK_HZ / 1000 * BLINK_OFF_MS;
  localparam int GAP_CYC = CLK_HZ / 1000 * GAP_MS;
  // edges after reset before the synchronised strap is trusted
  localparam logic [27:0] STRAP_WAIT_CYC = 28'h0000003;

  typedef enum logic [2:0] {ST_STRAP, ST_ON, ST_OFF, ST_GAP, ST_IDLE} rkd_state_e;

  typedef struct packed {
    logic [7:0] code;
    logic valid;
  } rkd_sample_s;

  typedef struct packed {
    logic [2:0] id;
    logic valid;
  } rkd_button_s;

  typedef struct packed {
    rkd_state_e state;
    logic [27:0] timer;
    logic [2:0] left;
    logic [2:0] burst;
    logic test_mode;
    logic led;
    rkd_button_s button;
    logic sel_s1;
    logic sel_s2;
  } rkd_state_s;
endpackage
